// ===== hdl/lpm_cfg.svh
// lpm_cfg.svh: constants of the low-power and indicator block
// assumes: included by bare name from the link interface, device, host and checker files
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// ********
// link widths and clock
// ********
`define LPM_AW          8
`define LPM_DW          16
`define LPM_CLK_MHZ     250

// ********
// timing: calibration and activity in microseconds, ack timeout in cycles
// ********
`define LPM_CAL_TIME_US 10000
`define LPM_ACT_TIME_US 6000
`define LPM_ACK_TMO     16

// ********
// device register offsets and fields
// ********
`define LPM_OFS_SCTL    8'h1e
`define LPM_OFS_IOBASE  8'h20
`define LPM_OFS_SSTAT   8'h22
`define LPM_SCTL_SWSUSP 8
`define LPM_SCTL_HWSLP  9
`define LPM_SCTL_HWSTBY 10
`define LPM_SCTL_HCEN   12
`define LPM_SCTL_HCLVL  14
`define LPM_SCTL_MASK   16'h5700
`define LPM_SCTL_RST    16'h0000
`define LPM_IOBASE_RST  16'h0000
`define LPM_SSTAT_INIT_DONE 7
`define LPM_SSTAT_SBUSY 8

// ********
// host controller registers on apb
// ********
`define LPM_H_CTRL      8'h00
`define LPM_H_ADDR      8'h04
`define LPM_H_WDATA     8'h08
`define LPM_H_RDATA     8'h0c
`define LPM_H_STS       8'h10
`define LPM_H_MASK      8'h14
`define LPM_CTRL_SLEEP  0
`define LPM_CTRL_GO     1
`define LPM_CTRL_WR     2
`define LPM_STS_DONE    0
`define LPM_STS_TMO     1
`define LPM_STS_REF     2
`define LPM_STS_W       3
`define LPM_STS_BUSY    8
`define LPM_STS_GUARD   9

`endif

// ===== hdl/lpm_pkg.sv
// lpm_pkg.sv: state types of both ends
// assumes: nothing beyond the compiler
package lpm_pkg;

   // device operating modes
   typedef enum logic [2:0] {
      LPM_INIT,
      LPM_ACTIVE,
      LPM_HW_STANDBY,
      LPM_HW_SUSPEND,
      LPM_SW_SUSPEND
   } lpm_mode_e;

   // host link sequencer
   typedef enum logic [1:0] {
      LPM_H_IDLE,
      LPM_H_REQ,
      LPM_H_WAIT
   } lpm_hstate_e;

endpackage

// ===== hdl/lpm_link_if.sv
// lpm_link_if.sv: sleep pin and register port between the two ends
// assumes: both ends on pclk; sleep_n is treated as a pin by the device
`timescale 1ns/1ps
`include "lpm_cfg.svh"
interface lpm_link_if;
   // sleep pin, low asks for hardware sleep
   logic                sleep_n;
   // register request
   logic                req;
   logic                wr;
   logic [`LPM_AW-1:0]  addr;
   logic [`LPM_DW-1:0]  wdata;
   // register answer
   logic                ack;
   logic [`LPM_DW-1:0]  rdata;

   modport dev (
      input  sleep_n,
      input  req,
      input  wr,
      input  addr,
      input  wdata,
      output ack,
      output rdata
   );

   modport host (
      output sleep_n,
      output req,
      output wr,
      output addr,
      output wdata,
      input  ack,
      input  rdata
   );
endinterface

// ===== hdl/lpm_device.sv
// lpm_device.sv: low-power sequencer and led pins of the device end
// assumes: host end drives the link on pclk, sleep_n may be asynchronous
// assumes: network events and link_ok come from logic on pclk
//
// How it works
// - leaving any low-power mode resets and self-configures
// - config done sets init_done, clears serial_busy
// - host waits calibration time before accessing registers; its guard is not restarted after a software wake
// - sleep low, sleep and standby enables: standby
// - standby: only receiver on, bus ignored
// - standby with link_ok high drives activity led low; network events are ignored
// - standby entry resets all but self control
// - sleep high leaves standby with complete reset
// - sleep low, sleep enable, no standby: suspend
// - sleep high leaves suspend with complete reset
// - software suspend bit keeps base and control only
// - any write wakes software suspend, data dropped
// - hardware reset ends every low-power mode
// - hardware modes override software suspend bit
// - activity led low, held six ms after activity
// - link led follows link pulses when not host
// - host control: link led shows inverted host bit
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module lpm_device #(
   parameter int CAL_CYC = `LPM_CAL_TIME_US * `LPM_CLK_MHZ,
   parameter int ACT_CYC = `LPM_ACT_TIME_US * `LPM_CLK_MHZ
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // link to the host end
   lpm_link_if.dev   lnk,
   // network side
   input  wire logic tx_evt,
   input  wire logic rx_evt,
   input  wire logic col_evt,
   input  wire logic link_ok,
   // indicator pins
   output logic      activity_led_n,
   output logic      link_led_n,
   // core control and status
   output logic      init_done,
   output logic      serial_busy,
   output logic      analog_en,
   output logic      rx_en,
   output logic      core_rst_n,
   output logic      low_power
);

   // ********
   // state
   // ********
   localparam int CW  = $clog2(CAL_CYC + 1);
   localparam int ACW = $clog2(ACT_CYC + 1);

   typedef struct packed {
      lpm_pkg::lpm_mode_e mode;
      logic               sl_s1;
      logic               sl_s2;
      logic               sl_s3;
      logic [15:0]        sctl;
      logic [15:0]        iobase;
      logic               init_done;
      logic               serial_busy;
      logic [CW-1:0]      cal_cnt;
      logic [ACW-1:0]     act_cnt;
      logic               ack;
      logic [15:0]        rdata;
      logic               act_led_n;
      logic               link_led_n;
      logic               analog_en;
      logic               rx_en;
      logic               core_rst_n;
      logic               low_power;
   } lpm_dev_s;

   // hardware reset lands in self-configuration
   localparam lpm_dev_s ST_RST = '{
      mode:        lpm_pkg::LPM_INIT,
      sl_s1:       1'b1, // pin idles high, no false edge
      sl_s2:       1'b1,
      sl_s3:       1'b1,
      sctl:        `LPM_SCTL_RST,
      iobase:      `LPM_IOBASE_RST,
      cal_cnt:     CW'(CAL_CYC - 1),
      serial_busy: 1'b1,
      act_led_n:   1'b1,
      link_led_n:  1'b1,
      default:     '0
   };

   lpm_dev_s st_r;
   lpm_dev_s st_nxt;

   logic     sleep_lo;
   logic     sleep_rise;
   logic     hw_mode;
   logic     awake;
   logic     wake;
   logic     evt;

   // ********
   // next state
   // ********
   // one pass; later blocks override earlier ones
   always_comb begin
      st_nxt     = st_r;
      wake       = 1'b0;
      evt        = tx_evt | rx_evt | col_evt;
      sleep_lo   = ~st_r.sl_s2;
      sleep_rise = st_r.sl_s2 & ~st_r.sl_s3;
      hw_mode    = (st_r.mode == lpm_pkg::LPM_HW_STANDBY) ||
                   (st_r.mode == lpm_pkg::LPM_HW_SUSPEND);

      // sleep pin synchroniser, third stage only for edges
      st_nxt.sl_s1 = lnk.sleep_n;
      st_nxt.sl_s2 = st_r.sl_s1;
      st_nxt.sl_s3 = st_r.sl_s2;

      st_nxt.ack        = 1'b0;
      st_nxt.core_rst_n = 1'b1;

      // mode sequencing and wake sources
      unique case (st_r.mode)
         lpm_pkg::LPM_INIT: begin
            if (st_r.cal_cnt == '0) begin
               st_nxt.mode        = lpm_pkg::LPM_ACTIVE;
               st_nxt.init_done   = 1'b1;
               st_nxt.serial_busy = 1'b0;
            end else begin
               st_nxt.cal_cnt = st_r.cal_cnt - 1'b1;
            end
         end
         lpm_pkg::LPM_ACTIVE: begin
         end
         lpm_pkg::LPM_HW_STANDBY: begin
            wake = sleep_rise;
         end
         lpm_pkg::LPM_HW_SUSPEND: begin
            wake = sleep_rise;
         end
         lpm_pkg::LPM_SW_SUSPEND: begin
            wake = lnk.req & lnk.wr;
         end
      endcase

      // register port; only active mode answers, so the host
      // cannot poll init_done and waits out its guard instead
      awake = (st_r.mode == lpm_pkg::LPM_ACTIVE);
      if (awake && lnk.req) begin
         st_nxt.ack   = 1'b1;
         st_nxt.rdata = '0;
         if (lnk.wr) begin
            if (lnk.addr == `LPM_OFS_SCTL) begin
               st_nxt.sctl = lnk.wdata & `LPM_SCTL_MASK;
            end else if (lnk.addr == `LPM_OFS_IOBASE) begin
               st_nxt.iobase = lnk.wdata;
            end
         end else begin
            case (lnk.addr)
               `LPM_OFS_SCTL: begin
                  st_nxt.rdata = st_r.sctl;
               end
               `LPM_OFS_IOBASE: begin
                  st_nxt.rdata = st_r.iobase;
               end
               `LPM_OFS_SSTAT: begin
                  st_nxt.rdata[`LPM_SSTAT_INIT_DONE] = st_r.init_done;
                  st_nxt.rdata[`LPM_SSTAT_SBUSY] = st_r.serial_busy;
               end
               default: begin
                  st_nxt.rdata = '0;
               end
            endcase
         end
      end

      // wake: complete reset then normal initialisation
      // base and control, less the suspend bit, survive so the host finds the part again
      if (wake) begin
         st_nxt.mode                 = lpm_pkg::LPM_INIT;
         st_nxt.cal_cnt              = CW'(CAL_CYC - 1);
         st_nxt.init_done            = 1'b0;
         st_nxt.serial_busy          = 1'b1;
         st_nxt.core_rst_n           = 1'b0;
         st_nxt.act_cnt              = '0;
         st_nxt.sctl[`LPM_SCTL_SWSUSP] = 1'b0;
      end

      // entry into low power; hardware modes checked first
      if (!hw_mode && sleep_lo && st_r.sctl[`LPM_SCTL_HWSLP]) begin
         if (st_r.sctl[`LPM_SCTL_HWSTBY]) begin
            st_nxt.mode        = lpm_pkg::LPM_HW_STANDBY;
            st_nxt.iobase      = `LPM_IOBASE_RST;
            st_nxt.init_done   = 1'b0;
            st_nxt.serial_busy = 1'b0;
            st_nxt.cal_cnt     = '0;
            st_nxt.act_cnt     = '0;
            st_nxt.core_rst_n  = 1'b0;
         end else begin
            st_nxt.mode = lpm_pkg::LPM_HW_SUSPEND;
         end
      end else if (!hw_mode && !wake &&
                   (st_r.mode != lpm_pkg::LPM_SW_SUSPEND) &&
                   st_r.sctl[`LPM_SCTL_SWSUSP]) begin
         st_nxt.mode = lpm_pkg::LPM_SW_SUSPEND;
      end

      // indicator pins follow the mode being entered
      if ((st_nxt.mode == lpm_pkg::LPM_ACTIVE) ||
          (st_nxt.mode == lpm_pkg::LPM_INIT)) begin
         if (evt) begin
            st_nxt.act_cnt = ACW'(ACT_CYC);
         end else if (st_nxt.act_cnt != '0) begin
            st_nxt.act_cnt = st_nxt.act_cnt - 1'b1;
         end
         st_nxt.act_led_n = (st_nxt.act_cnt == '0);
         if (st_nxt.sctl[`LPM_SCTL_HCEN]) begin
            st_nxt.link_led_n = ~st_nxt.sctl[`LPM_SCTL_HCLVL];
         end else begin
            st_nxt.link_led_n = ~link_ok;
         end
      end else if (st_nxt.mode == lpm_pkg::LPM_HW_STANDBY) begin
         st_nxt.act_led_n  = ~link_ok;
         st_nxt.link_led_n = 1'b1;
      end else begin
         // suspend modes leave both pins dark
         st_nxt.act_led_n  = 1'b1;
         st_nxt.link_led_n = 1'b1;
      end

      // power switches: receiver alone stays up in standby
      st_nxt.analog_en = (st_nxt.mode == lpm_pkg::LPM_ACTIVE) ||
                         (st_nxt.mode == lpm_pkg::LPM_INIT);
      st_nxt.rx_en     = st_nxt.analog_en ||
                         (st_nxt.mode == lpm_pkg::LPM_HW_STANDBY);
      st_nxt.low_power = ~st_nxt.analog_en;
   end

   // ********
   // registers
   // ********
   // hardware reset forces self-configuration from any mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign lnk.ack        = st_r.ack;
   assign lnk.rdata      = st_r.rdata;
   assign activity_led_n = st_r.act_led_n;
   assign link_led_n     = st_r.link_led_n;
   assign init_done      = st_r.init_done;
   assign serial_busy    = st_r.serial_busy;
   assign analog_en      = st_r.analog_en;
   assign rx_en          = st_r.rx_en;
   assign core_rst_n     = st_r.core_rst_n;
   assign low_power      = st_r.low_power;

endmodule

// ===== hdl/lpm_host.sv
// lpm_host.sv: host end, apb registers driving the sleep pin and link
// assumes: apb master on pclk; device end on the same clock
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module lpm_host #(
   parameter int CAL_CYC = `LPM_CAL_TIME_US * `LPM_CLK_MHZ,
   parameter int TMO     = `LPM_ACK_TMO
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt
   output logic             irq,
   // link to the device end
   lpm_link_if.host         lnk
);

   // ********
   // state
   // ********
   localparam int GW = $clog2(CAL_CYC + 1);
   localparam int TW = $clog2(TMO + 1);

   typedef struct packed {
      lpm_pkg::lpm_hstate_e  hs;
      logic                  sleep_n;
      logic                  req;
      logic                  wr;
      logic [`LPM_AW-1:0]    addr;
      logic [`LPM_DW-1:0]    wdata;
      logic [`LPM_DW-1:0]    rdat;
      logic [`LPM_STS_W-1:0] sts;
      logic [`LPM_STS_W-1:0] msk;
      logic                  irq;
      logic [TW-1:0]         tmo;
      logic [GW-1:0]         guard;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } lpm_host_s;

   // guard runs from reset: the device calibrates after it too
   localparam lpm_host_s ST_RST = '{
      hs:      lpm_pkg::LPM_H_IDLE,
      sleep_n: 1'b1,
      guard:   GW'(CAL_CYC),
      default: '0
   };

   lpm_host_s             st_r;
   lpm_host_s             st_nxt;
   logic                  setup;
   logic                  take;
   logic                  go;
   logic [`LPM_STS_W-1:0] set;
   logic [`LPM_STS_W-1:0] clr;

   // ********
   // next state
   // ********
   always_comb begin
      st_nxt         = st_r;
      setup          = psel & ~penable;
      take           = psel & penable & st_r.pready;
      go             = 1'b0;
      set            = '0;
      clr            = '0;
      st_nxt.pready  = setup;
      st_nxt.pslverr = 1'b0;
      st_nxt.req     = 1'b0;

      // read data latched in setup, shown in the access cycle
      if (setup) begin
         st_nxt.prdata = '0;
         case (paddr)
            `LPM_H_CTRL: begin
               st_nxt.prdata[`LPM_CTRL_SLEEP] = st_r.sleep_n;
               st_nxt.prdata[`LPM_CTRL_WR]    = st_r.wr;
            end
            `LPM_H_ADDR:  st_nxt.prdata[`LPM_AW-1:0] = st_r.addr;
            `LPM_H_WDATA: st_nxt.prdata[`LPM_DW-1:0] = st_r.wdata;
            `LPM_H_RDATA: st_nxt.prdata[`LPM_DW-1:0] = st_r.rdat;
            `LPM_H_STS: begin
               st_nxt.prdata[`LPM_STS_W-1:0] = st_r.sts;
               st_nxt.prdata[`LPM_STS_BUSY]  =
                  (st_r.hs != lpm_pkg::LPM_H_IDLE);
               st_nxt.prdata[`LPM_STS_GUARD] = (st_r.guard != '0);
            end
            `LPM_H_MASK:  st_nxt.prdata[`LPM_STS_W-1:0] = st_r.msk;
            default:      st_nxt.pslverr = 1'b1;
         endcase
      end

      // calibration guard counts down
      if (st_r.guard != '0) begin
         st_nxt.guard = st_r.guard - 1'b1;
      end

      // writes take effect only at the completing edge
      if (take && pwrite) begin
         case (paddr)
            `LPM_H_CTRL: begin
               st_nxt.sleep_n = pwdata[`LPM_CTRL_SLEEP];
               st_nxt.wr      = pwdata[`LPM_CTRL_WR];
               go             = pwdata[`LPM_CTRL_GO];
               if (pwdata[`LPM_CTRL_SLEEP] && !st_r.sleep_n) begin
                  st_nxt.guard = GW'(CAL_CYC);
               end
            end
            `LPM_H_ADDR:  st_nxt.addr  = pwdata[`LPM_AW-1:0];
            `LPM_H_WDATA: st_nxt.wdata = pwdata[`LPM_DW-1:0];
            `LPM_H_STS:   clr          = pwdata[`LPM_STS_W-1:0];
            `LPM_H_MASK:  st_nxt.msk   = pwdata[`LPM_STS_W-1:0];
            default: begin
            end
         endcase
      end

      // link sequencer; a silent device ends in a timeout,
      // which is the normal answer to a wake-up write
      unique case (st_r.hs)
         lpm_pkg::LPM_H_IDLE: begin
            if (go && (st_r.guard != '0)) begin
               set[`LPM_STS_REF] = 1'b1;
            end else if (go) begin
               st_nxt.hs  = lpm_pkg::LPM_H_REQ;
               st_nxt.req = 1'b1;
            end
         end
         lpm_pkg::LPM_H_REQ: begin
            st_nxt.hs  = lpm_pkg::LPM_H_WAIT;
            st_nxt.tmo = TW'(TMO);
         end
         lpm_pkg::LPM_H_WAIT: begin
            if (lnk.ack) begin
               st_nxt.rdat        = lnk.rdata;
               set[`LPM_STS_DONE] = 1'b1;
               st_nxt.hs          = lpm_pkg::LPM_H_IDLE;
            end else if (st_r.tmo == '0) begin
               set[`LPM_STS_TMO] = 1'b1;
               st_nxt.hs         = lpm_pkg::LPM_H_IDLE;
            end else begin
               st_nxt.tmo = st_r.tmo - 1'b1;
            end
         end
      endcase
      if (go && (st_r.hs != lpm_pkg::LPM_H_IDLE)) begin
         set[`LPM_STS_REF] = 1'b1;
      end

      // sticky flags: a new event beats a same-cycle clear
      st_nxt.sts = (st_r.sts & ~clr) | set;
      st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
   end

   // ********
   // registers
   // ********
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign prdata      = st_r.prdata;
   assign pready      = st_r.pready;
   assign pslverr     = st_r.pslverr;
   assign irq         = st_r.irq;
   assign lnk.sleep_n = st_r.sleep_n;
   assign lnk.req     = st_r.req;
   assign lnk.wr      = st_r.wr;
   assign lnk.addr    = st_r.addr;
   assign lnk.wdata   = st_r.wdata;

endmodule

// ===== bench/lpm_properties.sv
// lpm_properties.sv: link checker for the low-power block
// assumes: one pclk domain, inputs taken straight off the link interface
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module lpm_properties #(
   parameter int CAL_CYC = 40
) (
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // link signals
   input wire logic              sleep_n,
   input wire logic              req,
   input wire logic              wr,
   input wire logic [`LPM_AW-1:0] addr,
   input wire logic [`LPM_DW-1:0] wdata,
   input wire logic              ack,
   input wire logic [`LPM_DW-1:0] rdata
);
   logic        pw_r;
   logic [7:0]  pa_r;
   logic [15:0] pd_r;
   logic [15:0] sc_r;
   logic [15:0] io_r;
   logic        sw_r;
   int          lo_r;
   int          ic_r;
   wire logic   hw;
   wire logic   rd_ack;

   // pin low long enough to pass the two-stage sync
   assign hw = lo_r >= 4 && sc_r[9];
   assign rd_ack = ack && !pw_r;

   // shadows and mode guesses from answered requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_r <= 1'b0;
         pa_r <= 8'h00;
         pd_r <= 16'h0000;
         sc_r <= 16'h0000;
         io_r <= 16'h0000;
         sw_r <= 1'b0;
         lo_r <= 0;
         ic_r <= CAL_CYC;
      end else begin
         if (req) begin
            pw_r <= wr;
            pa_r <= addr;
            pd_r <= wdata;
         end
         lo_r <= sleep_n ? 0 : (lo_r < 8 ? lo_r + 1 : lo_r);
         ic_r <= ic_r > 0 ? ic_r - 1 : 0;
         if (ack && pw_r && pa_r == 8'h1e) begin
            sc_r <= pd_r & 16'h5700;
            sw_r <= pd_r[8];
         end
         if (ack && pw_r && pa_r == 8'h20) begin
            io_r <= pd_r;
         end
         if (hw && sc_r[10]) begin
            io_r <= 16'h0000;
         end
         // wake: the write is dropped and calibration starts over
         if ((sw_r && req && wr) || (sleep_n && hw)) begin
            sw_r <= 1'b0;
            sc_r[8] <= 1'b0;
            ic_r <= CAL_CYC;
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_hw_bus_ignored: assert property (
      hw && req |=> !ack) else $error("answer in hardware sleep");
   chk_sw_bus_ignored: assert property (
      sw_r && req |=> !ack) else $error("answer in software suspend");
   chk_init_no_answer: assert property (
      ack |-> ic_r == 0) else $error("answer during calibration");
   chk_answer_needs_req: assert property (
      ack |-> $past(req)) else $error("answer without request");
   chk_status_ready: assert property (
      rd_ack && pa_r == 8'h22 |-> rdata[7] && !rdata[8])
      else $error("status not ready");
   chk_ctrl_kept: assert property (
      rd_ack && pa_r == 8'h1e |-> rdata == sc_r)
      else $error("control word differs");
   chk_iobase_kept: assert property (
      rd_ack && pa_r == 8'h20 |-> rdata == io_r)
      else $error("base word differs");
   chk_unmapped_zero: assert property (
      rd_ack && !(pa_r inside {8'h1e, 8'h20, 8'h22}) |-> rdata == 16'h0)
      else $error("unmapped read not zero");

   cov_sw_wake: cover property (sw_r && req && wr);
   cov_hw_req: cover property (hw && req);
   cov_status: cover property (rd_ack && pa_r == 8'h22);
endmodule

// ===== bench/low_power_mode_and_led_control_test.sv
// low_power_mode_and_led_control_test.sv: both ends joined, apb driven
// assumes: hdl files compiled first; short calibration and led counts
`timescale 1ns/1ps
module low_power_mode_and_led_control_test;
   localparam int CAL = 40;
   localparam int ACT = 20;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic        pwrite = 0, pready, pslverr, irq, slp = 1, er;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, st;
   logic        tx_evt = 0, rx_evt = 0, col_evt = 0, link_ok = 0;
   logic        activity_led_n, link_led_n, init_done, serial_busy;
   logic        analog_en, rx_en, core_rst_n, low_power;
   logic [15:0] lrd, v;
   int          fail_count = 0, compares = 0, seed, i;

   lpm_link_if lk ();
   lpm_host #(.CAL_CYC(CAL)) i_lpm_host (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lk));
   lpm_device #(.CAL_CYC(CAL), .ACT_CYC(ACT)) i_lpm_device (
      .pclk(pclk), .presetn(presetn), .lnk(lk), .tx_evt(tx_evt),
      .rx_evt(rx_evt), .col_evt(col_evt), .link_ok(link_ok),
      .activity_led_n(activity_led_n), .link_led_n(link_led_n),
      .init_done(init_done), .serial_busy(serial_busy),
      .analog_en(analog_en), .rx_en(rx_en), .core_rst_n(core_rst_n),
      .low_power(low_power));
   lpm_properties #(.CAL_CYC(CAL)) u_chk (
      .pclk(pclk), .presetn(presetn), .sleep_n(lk.sleep_n), .req(lk.req),
      .wr(lk.wr), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack),
      .rdata(lk.rdata));

   // 250 MHz clock
   always #2 pclk = ~pclk;

   // ********
   // tasks
   // ********
   task tally_and_finish;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task ck(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // expected link pin: inverted host bit when host owns it, else inverted link pulses
   function automatic logic exp_link(input logic en, lvl, ok);
      return en ? !lvl : !ok;
   endfunction

   // one apb transfer; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 20) begin
         ck("pready", 1, 0);
         tally_and_finish;
      end
   endtask

   // one link operation through the host registers
   task lop(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      apb(1, 8'h10, 32'h7);
      apb(1, 8'h04, {24'h0, a});
      apb(1, 8'h08, {16'h0, d});
      apb(1, 8'h00, {29'h0, w, 1'b1, slp});
      n = 0;
      do begin
         apb(0, 8'h10, 32'h0);
         n++;
      end while (rd[2:0] == 3'h0 && n < 60);
      st = rd;
      apb(0, 8'h0c, 32'h0);
      lrd = rd[15:0];
      if (n >= 60) begin
         ck("link_end", 1, 0);
         tally_and_finish;
      end
   endtask

   task ev(input int k);
      @(posedge pclk);
      {col_evt, rx_evt, tx_evt} <= 3'h1 << k;
      @(posedge pclk);
      {col_evt, rx_evt, tx_evt} <= 3'h0;
   endtask

   // ********
   // main sequence
   // ********
   initial begin
      seed = 29;
      wt(8);
      presetn <= 1;
      lop(0, 8'h22, 16'h0);
      ck("refused", 1, st[2]);
      ck("guard", 1, st[9]);
      ck("busy_cal", 1, serial_busy);
      wt(CAL);
      ck("init_done", 1, init_done);
      ck("sbusy", 0, serial_busy);
      lop(0, 8'h22, 16'h0);
      ck("sstat", 2'b01, lrd[8:7]);
      lop(0, 8'h1e, 16'h0);
      ck("sctl_rst", 0, lrd);
      lop(0, 8'h20, 16'h0);
      ck("iob_rst", 0, lrd);
      // random control words, suspend bit kept clear
      for (i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         lop(1, 8'h1e, v & 16'hfeff);
         lop(0, 8'h1e, 16'h0);
         ck("sctl", v & 16'h5600, lrd);
         lop(1, 8'h20, v);
         lop(0, 8'h20, 16'h0);
         ck("iob", v, lrd);
      end
      lop(0, 8'h40, 16'h0);
      ck("unmapped", 0, lrd);
      apb(0, 8'h18, 32'h0);
      ck("pslverr", 1, er);
      // link led under device and host control
      for (i = 0; i < 4; i++) begin
         lop(1, 8'h1e, {1'b0, i[1], 1'b0, i[0], 12'h0});
         link_ok <= ~i[1];
         wt(3);
         ck("link_led", exp_link(i[0], i[1], link_ok), link_led_n);
      end
      lop(1, 8'h1e, 16'h0);
      link_ok <= 0;
      // stretch per event kind, retriggered before it runs out
      for (i = 0; i < 3; i++) begin
         ev(i);
         wt(ACT - 5);
         ck("act_mid", 0, activity_led_n);
         ev(i);
         wt(ACT - 2);
         ck("act_retrig", 0, activity_led_n);
         wt(5);
         ck("act_off", 1, activity_led_n);
      end
      // interrupt raised, masked, cleared
      apb(1, 8'h14, 32'h1);
      lop(0, 8'h22, 16'h0);
      wt(2);
      ck("irq", 1, irq);
      apb(1, 8'h14, 32'h0);
      wt(2);
      ck("irq_mask", 0, irq);
      apb(1, 8'h14, 32'h1);
      apb(1, 8'h10, 32'h1);
      wt(2);
      ck("irq_clr", 0, irq);
      apb(1, 8'h14, 32'h0);
      // software suspend, woken by a dropped write
      lop(1, 8'h20, 16'h1234);
      lop(1, 8'h1e, 16'h0100);
      wt(3);
      ck("sw_lp", 1, low_power);
      ck("sw_an", 0, analog_en);
      lop(0, 8'h20, 16'h0);
      ck("sw_ign", 1, st[1]);
      lop(1, 8'h20, 16'hdead);
      ck("wake_wr", 1, st[1]);
      wt(CAL + 4);
      ck("sw_up", 0, low_power);
      lop(0, 8'h20, 16'h0);
      ck("iob_kept", 16'h1234, lrd);
      lop(0, 8'h1e, 16'h0);
      ck("sctl_wake", 0, lrd);
      // standby then suspend with the sleep pin low
      for (i = 0; i < 2; i++) begin
         v = i ? 16'h0200 : 16'h0600;
         lop(1, 8'h1e, 16'h0);
         lop(1, 8'h20, 16'h00ab);
         slp = 0;
         apb(1, 8'h00, 32'h0);
         wt(4);
         lop(0, 8'h22, 16'h0);
         ck("pin_only", 1, st[0]);
         lop(1, 8'h1e, v);
         wt(4);
         link_ok <= 1;
         ev(0);
         wt(3);
         ck("hw_lp", 1, low_power);
         ck("hw_an", 0, analog_en);
         ck("hw_rx", !i, rx_en);
         ck("hw_act", i, activity_led_n);
         lop(0, 8'h22, 16'h0);
         ck("hw_ign", 1, st[1]);
         slp = 1;
         apb(1, 8'h00, 32'h1);
         wt(4);
         ck("wake_rst", 0, core_rst_n);
         wt(CAL + 4);
         link_ok <= 0;
         ck("hw_up", 0, low_power);
         lop(0, 8'h20, 16'h0);
         ck("hw_iob", i ? 16'h00ab : 16'h0, lrd);
         lop(0, 8'h1e, 16'h0);
         ck("hw_sctl", v, lrd);
      end
      // hardware reset while suspended
      lop(1, 8'h1e, 16'h0100);
      wt(3);
      presetn <= 0;
      wt(2);
      ck("rst_core", 0, core_rst_n);
      presetn <= 1;
      wt(CAL + 4);
      ck("rst_lp", 0, low_power);
      lop(0, 8'h1e, 16'h0);
      ck("rst_sctl", 0, lrd);
      tally_and_finish;
   end
endmodule
